// ==== core/dps_sideband.sv ====
`timescale 1ns/1ps
`default_nettype none

module dps_sideband #(
  parameter int CNT_W = 8
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Avalon-MM slave
  input  wire logic [4:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic [31:0]                 o_avs_readdata,
  output logic                        o_avs_waitrequest,
  output logic                        o_irq,
  // Core side
  input  wire logic                   i_phy_link_up,
  input  wire logic                   i_fc_init_done,
  input  wire logic                   i_tl_ready,
  input  wire logic                   i_tlp_stored,
  input  wire logic                   i_tlp_acked,
  input  wire logic                   i_rx_tlp,
  input  wire dps_pkg::dps_dllp_t     i_rx_dllp,
  output dps_pkg::dps_dllp_t          o_tx_dllp,
  input  wire logic                   i_tx_dllp_ready,
  // User side
  output logic                        o_link_layer_idle_flag,
  output logic                        o_link_layer_initialising_flag,
  output logic                        o_link_layer_running_flag,
  output logic                        o_link_layer_forwarding_flag,
  input  wire logic [1:0]             i_tx_dllp_cmd,
  input  wire logic [2:0]             i_tx_pm_type,
  input  wire logic [23:0]            i_tx_vsd_data,
  output logic                        o_tx_dllp_sent,
  output logic [2:0]                  o_rx_pm_type,
  output logic [23:0]                 o_rx_vsd_data,
  output logic                        o_rx_dllp_valid,
  output logic                        o_tx_rbuf_empty,
  output logic                        o_tx_dllp_pend,
  output logic                        o_rx_tlp_rcvd
);
  import dps_pkg::*;

  generate
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad_cnt
      $error("CNT_W must lie in 2..16");
    end
  endgenerate

  function automatic logic pm_code_ok(input logic [2:0] t);
    pm_code_ok = (t == PM_ENTER_L1) || (t == PM_ENTER_L2) ||
                 (t == PM_ASPM_L1) || (t == PM_REQ_ACK);
  endfunction

  dps_dl_state_t    dl_q;
  dps_tx_state_t    tx_q;
  logic             fwd_q;
  logic             fwd_d1_q;
  logic [CNT_W-1:0] unack_q;
  logic             sent_q;
  logic             rxv_q;
  logic [2:0]       rxt_q;
  logic [23:0]      rxd_q;
  logic             rxtlp_q;
  dps_dllp_t        txd_q;
  logic [31:0]      ctrl_q;
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] imk_q;
  logic [IRQ_W-1:0] ev;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             req;
  logic             wr_go;
  logic             link_en;
  logic             rx_pm;
  logic             rx_vsd;
  logic             tx_fire;
  logic [31:0]      status;
  logic [31:0]      wmask;

  assign link_en = ctrl_q[CTRL_LINK_EN];

  // Link layer state, sampled on the system clock
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dl_q <= DPS_INACTIVE;
    end
    else if (!i_phy_link_up || !link_en)
    begin
      dl_q <= DPS_INACTIVE;
    end
    else
    begin
      case (dl_q)
        DPS_INACTIVE: dl_q <= DPS_INIT;
        DPS_INIT:     dl_q <= i_fc_init_done ? DPS_ACTIVE : DPS_INIT;
        DPS_ACTIVE:   dl_q <= DPS_ACTIVE;
        default:      dl_q <= DPS_INACTIVE;
      endcase
    end
  end

  // Forwarding trails activity by one cycle so TL sees a settled link
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      fwd_q <= 1'b0;
    else
      fwd_q <= (dl_q == DPS_ACTIVE) && i_phy_link_up && link_en && i_tl_ready;
  end

  assign o_link_layer_idle_flag         = (dl_q == DPS_INACTIVE);
  assign o_link_layer_initialising_flag = (dl_q == DPS_INIT);
  assign o_link_layer_running_flag      = (dl_q == DPS_ACTIVE);
  assign o_link_layer_forwarding_flag   = fwd_q;

  // Unacknowledged packet count; saturates rather than wraps
  always_ff @(posedge i_clk)
  begin
    if (i_rst || dl_q == DPS_INACTIVE)
    begin
      unack_q <= '0;
    end
    else if (i_tlp_stored && !i_tlp_acked && unack_q != '1)
    begin
      unack_q <= unack_q + 1'b1;
    end
    else if (i_tlp_acked && !i_tlp_stored && unack_q != '0)
    begin
      unack_q <= unack_q - 1'b1;
    end
  end

  assign o_tx_rbuf_empty = (unack_q == '0);

  // Transmit request: latch, wait for the transmitter, then wait for release
  assign tx_fire = (tx_q == DPS_TX_PEND) && i_tx_dllp_ready;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_q  <= DPS_TX_IDLE;
      txd_q <= '0;
    end
    else
    begin
      case (tx_q)
        DPS_TX_IDLE:
        begin
          if (i_tx_dllp_cmd == CMD_PM && pm_code_ok(i_tx_pm_type))
          begin
            txd_q.valid <= 1'b1;
            txd_q.data  <= {DLLP_PM_PFX, i_tx_pm_type, 24'h000000};
            tx_q        <= DPS_TX_PEND;
          end
          else if (i_tx_dllp_cmd == CMD_VSD)
          begin
            txd_q.valid <= 1'b1;
            txd_q.data  <= {DLLP_VSD, i_tx_vsd_data};
            tx_q        <= DPS_TX_PEND;
          end
        end
        DPS_TX_PEND:
        begin
          if (i_tx_dllp_ready)
          begin
            txd_q.valid <= 1'b0;
            tx_q        <= DPS_TX_HOLD;
          end
        end
        DPS_TX_HOLD:
        begin
          // Command still up after the pulse must not send twice
          if (i_tx_dllp_cmd == CMD_NONE)
          begin
            tx_q <= DPS_TX_IDLE;
          end
        end
        default: tx_q <= DPS_TX_IDLE;
      endcase
    end
  end

  assign o_tx_dllp      = txd_q;
  assign o_tx_dllp_pend = txd_q.valid;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sent_q <= 1'b0;
    else
      sent_q <= tx_fire;
  end

  assign o_tx_dllp_sent = sent_q;

  // Receive decode; unknown DLLP types are dropped silently
  assign rx_pm  = i_rx_dllp.valid && (i_rx_dllp.data[31:27] == DLLP_PM_PFX) &&
                  pm_code_ok(i_rx_dllp.data[26:24]);
  assign rx_vsd = i_rx_dllp.valid && (i_rx_dllp.data[31:24] == DLLP_VSD);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rxv_q <= 1'b0;
      rxt_q <= PM_ENTER_L1;
      rxd_q <= '0;
    end
    else
    begin
      rxv_q <= rx_pm || rx_vsd;
      if (rx_pm)
      begin
        rxt_q <= i_rx_dllp.data[26:24];
      end
      if (rx_vsd)
      begin
        rxd_q <= i_rx_dllp.data[23:0];
      end
    end
  end

  assign o_rx_dllp_valid = rxv_q;
  assign o_rx_pm_type    = rxt_q;
  assign o_rx_vsd_data   = rxd_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rxtlp_q <= 1'b0;
    else
      rxtlp_q <= i_rx_tlp;
  end

  assign o_rx_tlp_rcvd = rxtlp_q;

  // Avalon slave: one wait cycle on every access
  assign req               = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_q;
  assign wr_go             = i_avs_write && ack_q;
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                  {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  always_comb
  begin
    status          = '0;
    status[ST_IDLE] = o_link_layer_idle_flag;
    status[ST_INIT] = o_link_layer_initialising_flag;
    status[ST_RUN]  = o_link_layer_running_flag;
    status[ST_FWD]  = fwd_q;
    status[ST_RBE]  = o_tx_rbuf_empty;
    status[ST_PEND] = txd_q.valid;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= '0;
    end
    else if (i_avs_read && !ack_q)
    begin
      if (i_avs_address == OFS_STATUS)
        rdata_q <= status;
      else if (i_avs_address == OFS_IRQ_ST)
        rdata_q <= {{(32-IRQ_W){1'b0}}, ist_q};
      else if (i_avs_address == OFS_IRQ_MK)
        rdata_q <= {{(32-IRQ_W){1'b0}}, imk_q};
      else if (i_avs_address == OFS_CTRL)
        rdata_q <= ctrl_q;
      else if (i_avs_address == OFS_RXINFO)
        rdata_q <= {5'h00, rxt_q, rxd_q};
      else
        rdata_q <= '0;
    end
  end

  assign o_avs_readdata = rdata_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_q <= CTRL_RST;
      imk_q  <= MASK_RST;
    end
    else if (wr_go)
    begin
      if (i_avs_address == OFS_CTRL)
        ctrl_q <= {31'h00000000, (i_avs_writedata[0] & wmask[0]) | (ctrl_q[0] & ~wmask[0])};
      else if (i_avs_address == OFS_IRQ_MK)
        imk_q <= (i_avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]) |
                 (imk_q & ~wmask[IRQ_W-1:0]);
    end
  end

  // Interrupt events; a new event wins over a same-cycle clear
  always_comb
  begin
    ev             = '0;
    ev[IRQ_UP]     = fwd_q && !fwd_d1_q;
    ev[IRQ_DOWN]   = fwd_d1_q && !fwd_q;
    ev[IRQ_SENT]   = sent_q;
    ev[IRQ_RXDLLP] = rxv_q;
    ev[IRQ_RXTLP]  = rxtlp_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      fwd_d1_q <= 1'b0;
    else
      fwd_d1_q <= fwd_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ist_q <= '0;
    end
    else
    begin
      if (wr_go && i_avs_address == OFS_IRQ_ST)
        ist_q <= (ist_q & ~(i_avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0])) | ev;
      else
        ist_q <= ist_q | ev;
    end
  end

  assign o_irq = |(ist_q & imk_q);

endmodule // dps_sideband

`default_nettype wire

// ==== core/dps_pkg.sv ====
`default_nettype none
package dps_pkg;
  // Avalon register byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_IRQ_ST = 5'h04;
  localparam logic [4:0] OFS_IRQ_MK = 5'h08;
  localparam logic [4:0] OFS_CTRL   = 5'h0c;
  localparam logic [4:0] OFS_RXINFO = 5'h10;

  // Status register fields
  localparam int ST_IDLE = 0;
  localparam int ST_INIT = 1;
  localparam int ST_RUN  = 2;
  localparam int ST_FWD  = 3;
  localparam int ST_RBE  = 4;
  localparam int ST_PEND = 5;

  // Interrupt bits
  localparam int IRQ_W      = 5;
  localparam int IRQ_UP     = 0;
  localparam int IRQ_DOWN   = 1;
  localparam int IRQ_SENT   = 2;
  localparam int IRQ_RXDLLP = 3;
  localparam int IRQ_RXTLP  = 4;

  // Control register fields and reset values
  localparam int CTRL_LINK_EN = 0;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

  // Send command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_PM   = 2'h1;
  localparam logic [1:0] CMD_VSD  = 2'h2;

  // Power message type codes
  localparam logic [2:0] PM_ENTER_L1 = 3'h0;
  localparam logic [2:0] PM_ENTER_L2 = 3'h1;
  localparam logic [2:0] PM_ASPM_L1  = 3'h3;
  localparam logic [2:0] PM_REQ_ACK  = 3'h4;

  // DLLP type byte: PM prefix over the 3-bit type, vendor type whole
  localparam logic [4:0] DLLP_PM_PFX = 5'h04;
  localparam logic [7:0] DLLP_VSD    = 8'h30;

  typedef enum logic [1:0] {
    DPS_INACTIVE = 2'b00,
    DPS_INIT     = 2'b01,
    DPS_ACTIVE   = 2'b10
  } dps_dl_state_t;

  typedef enum logic [1:0] {
    DPS_TX_IDLE = 2'b00,
    DPS_TX_PEND = 2'b01,
    DPS_TX_HOLD = 2'b10
  } dps_tx_state_t;

  // One DLLP word: type byte over 24-bit payload
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } dps_dllp_t;
endpackage
`default_nettype wire

// ==== verification/dps_sideband_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dps_sideband_chk
  import dps_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_phy_link_up,
  input wire logic        i_rx_tlp,
  input wire dps_dllp_t   i_rx_dllp,
  input wire dps_dllp_t   o_tx_dllp,
  input wire logic        i_tx_dllp_ready,
  input wire logic        o_link_layer_idle_flag,
  input wire logic        o_link_layer_initialising_flag,
  input wire logic        o_link_layer_running_flag,
  input wire logic        o_link_layer_forwarding_flag,
  input wire logic [1:0]  i_tx_dllp_cmd,
  input wire logic [2:0]  i_tx_pm_type,
  input wire logic [23:0] i_tx_vsd_data,
  input wire logic        o_tx_dllp_sent,
  input wire logic [2:0]  o_rx_pm_type,
  input wire logic [23:0] o_rx_vsd_data,
  input wire logic        o_rx_dllp_valid,
  input wire logic        o_tx_dllp_pend,
  input wire logic        o_rx_tlp_rcvd
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_idle_on_down: assert property (!i_phy_link_up |=> o_link_layer_idle_flag)
    else $error("idle flag missing after link loss");
  a_state_onehot: assert property ($onehot({o_link_layer_idle_flag,
    o_link_layer_initialising_flag, o_link_layer_running_flag}))
    else $error("link state flags not one-hot");
  a_fwd_when_run: assert property (o_link_layer_forwarding_flag
    |-> o_link_layer_running_flag) else $error("forwarding without running");
  a_vsd_word: assert property ($rose(o_tx_dllp.valid) && $past(i_tx_dllp_cmd) == CMD_VSD
    |-> o_tx_dllp.data == {DLLP_VSD, $past(i_tx_vsd_data)}) else $error("bad vendor word");
  a_pm_word: assert property ($rose(o_tx_dllp.valid) && $past(i_tx_dllp_cmd) == CMD_PM
    |-> o_tx_dllp.data == {DLLP_PM_PFX, $past(i_tx_pm_type), 24'h0}) else $error("bad pm word");
  a_sent_after_take: assert property (o_tx_dllp.valid && i_tx_dllp_ready
    |=> o_tx_dllp_sent ##1 !o_tx_dllp_sent) else $error("sent pulse wrong");
  a_pend_tracks: assert property (o_tx_dllp_pend && !i_tx_dllp_ready
    |=> o_tx_dllp_pend && o_tx_dllp.valid) else $error("pending flag dropped before take");
  a_tlp_echo: assert property (i_rx_tlp |=> o_rx_tlp_rcvd)
    else $error("tlp received pulse missing");
  a_rx_vendor: assert property (i_rx_dllp.valid && i_rx_dllp.data[31:24] == DLLP_VSD
    |=> o_rx_dllp_valid && o_rx_vsd_data == $past(i_rx_dllp.data[23:0]))
    else $error("vendor receive wrong");
  a_rx_pm: assert property (i_rx_dllp.valid && i_rx_dllp.data[31:27] == DLLP_PM_PFX
    && i_rx_dllp.data[26:24] inside {3'h0, 3'h1, 3'h3, 3'h4}
    |=> o_rx_dllp_valid && o_rx_pm_type == $past(i_rx_dllp.data[26:24]))
    else $error("pm receive wrong");
endmodule // dps_sideband_chk
bind dps_sideband dps_sideband_chk dps_sideband_chk_inst (.i_clk, .i_rst, .i_phy_link_up,
  .i_rx_tlp, .i_rx_dllp, .o_tx_dllp, .i_tx_dllp_ready, .o_link_layer_idle_flag,
  .o_link_layer_initialising_flag, .o_link_layer_running_flag, .o_link_layer_forwarding_flag,
  .i_tx_dllp_cmd, .i_tx_pm_type, .i_tx_vsd_data, .o_tx_dllp_sent, .o_rx_pm_type,
  .o_rx_vsd_data, .o_rx_dllp_valid, .o_tx_dllp_pend, .o_rx_tlp_rcvd);
`default_nettype wire

// ==== verification/dps_user_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dps_user_model
  import dps_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_kind,
  input  wire logic [2:0]  i_type,
  input  wire logic [23:0] i_data,
  input  wire logic        i_sent,
  output logic [1:0]       o_cmd,
  output logic [2:0]       o_type,
  output logic [23:0]      o_data
);
  // Held until the sent pulse, then dropped; payload inverted so stale data never looks valid
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_cmd <= CMD_NONE;
    else if (i_sent)
    begin
      o_cmd <= CMD_NONE;
      o_type <= ~o_type;
      o_data <= ~o_data;
    end
    else if (i_go && o_cmd == CMD_NONE)
    begin
      o_cmd <= i_kind;
      o_type <= i_type;
      o_data <= i_data;
    end
  end
endmodule // dps_user_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import dps_pkg::*;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, phy = 0, fc = 0, tl = 0;
  logic        stored = 0, acked = 0, tlp = 0, ready = 0, go = 0, wait_rq, irq;
  logic [4:0]  addr = 0;
  logic [31:0] wdata = 0, rdata, q;
  logic [1:0]  kind = 0, cmd;
  logic [2:0]  ptype = 0, utype, rx_pm, exp_pm = 0;
  logic [23:0] pdata = 0, udata, rx_vsd, exp_vsd = 0;
  logic        f_idle, f_init, f_run, f_fwd, sent, rx_val, rbe, pend, tlp_seen;
  dps_dllp_t   rxd = '0, txd;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [31:0] exp_q[$];
  logic [2:0]  pm_codes[4] = '{PM_ENTER_L1, PM_ENTER_L2, PM_ASPM_L1, PM_REQ_ACK};

  dps_sideband dps_sideband_inst (.i_clk(clk), .i_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .o_irq(irq), .i_phy_link_up(phy),
    .i_fc_init_done(fc), .i_tl_ready(tl), .i_tlp_stored(stored), .i_tlp_acked(acked),
    .i_rx_tlp(tlp), .i_rx_dllp(rxd), .o_tx_dllp(txd), .i_tx_dllp_ready(ready),
    .o_link_layer_idle_flag(f_idle), .o_link_layer_initialising_flag(f_init),
    .o_link_layer_running_flag(f_run), .o_link_layer_forwarding_flag(f_fwd),
    .i_tx_dllp_cmd(cmd), .i_tx_pm_type(utype), .i_tx_vsd_data(udata), .o_tx_dllp_sent(sent),
    .o_rx_pm_type(rx_pm), .o_rx_vsd_data(rx_vsd), .o_rx_dllp_valid(rx_val),
    .o_tx_rbuf_empty(rbe), .o_tx_dllp_pend(pend), .o_rx_tlp_rcvd(tlp_seen));
  dps_user_model dps_user_model_inst (.i_clk(clk), .i_rst(rst), .i_go(go), .i_kind(kind),
    .i_type(ptype), .i_data(pdata), .i_sent(sent), .o_cmd(cmd), .o_type(utype), .o_data(udata));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Values seen right after the edge are the ones the edge sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_rq !== 1'b0)
      @(posedge clk);
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask

  task automatic send(input logic [1:0] k, input logic [2:0] t, input logic [23:0] d);
    logic        fired;
    logic [31:0] exp_w;
    fired = 1'b0;
    exp_q.push_back(k == CMD_VSD ? {DLLP_VSD, d} : {DLLP_PM_PFX, t, 24'h0});
    @(posedge clk);
    go <= 1;
    kind <= k;
    ptype <= t;
    pdata <= d;
    @(posedge clk);
    go <= 0;
    // Ready drawn once per edge so it is never assigned twice in one step
    while (!fired)
    begin
      @(posedge clk);
      fired = (txd.valid === 1'b1 && ready === 1'b1);
      ready <= !fired && ($urandom % 3 == 0);
    end
    exp_w = exp_q.pop_front();
    `CHK(txd.data, exp_w)
    `CHK(pend, 1'b1)
    @(posedge clk);
    `CHK({sent, pend}, 2'b10)
  endtask

  task automatic rx(input logic [31:0] w, input logic ok);
    @(posedge clk);
    rxd <= '{1'b1, w};
    @(posedge clk);
    rxd.valid <= 0;
    @(posedge clk);
    `CHK(rx_val, ok)
    `CHK({rx_pm, rx_vsd}, {exp_pm, exp_vsd})
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(21613));
    repeat (8) @(posedge clk);
    rst <= 0;
    bus(0, OFS_STATUS, 0);
    `CHK(q, 32'h11)
    bus(1, 5'h14, 32'hffff_ffff);
    bus(0, 5'h14, 0);
    `CHK(q, 32'h0)
    @(posedge clk) phy <= 1;
    repeat (2) @(posedge clk);
    `CHK(f_init, 1'b1)
    fc <= 1;
    tl <= 1;
    repeat (2) @(posedge clk);
    `CHK({f_run, f_fwd}, 2'b10)
    @(posedge clk);
    `CHK(f_fwd, 1'b1)
    bus(0, OFS_IRQ_ST, 0);
    `CHK(q, 32'h01)
    `CHK(irq, 1'b0)
    bus(1, OFS_IRQ_MK, 32'h1f);
    @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1, OFS_IRQ_ST, 32'h1f);
    @(posedge clk);
    `CHK(irq, 1'b0)
    foreach (pm_codes[i]) send(CMD_PM, pm_codes[i], 24'h0);
    repeat (3) send(CMD_VSD, 3'h0, 24'($urandom));
    bus(0, OFS_IRQ_ST, 0);
    `CHK(q, 32'h04)
    foreach (pm_codes[i])
    begin
      exp_pm = pm_codes[i];
      rx({DLLP_PM_PFX, pm_codes[i], 24'($urandom)}, 1'b1);
    end
    exp_vsd = 24'($urandom);
    rx({DLLP_VSD, exp_vsd}, 1'b1);
    rx(32'h55aa_0000, 1'b0);
    bus(0, OFS_RXINFO, 0);
    `CHK(q, {5'h0, exp_pm, exp_vsd})
    @(posedge clk) stored <= 1;
    @(posedge clk)
    begin
      stored <= 0;
      tlp <= 1;
    end
    @(posedge clk) tlp <= 0;
    @(posedge clk);
    `CHK({rbe, tlp_seen}, 2'b01)
    acked <= 1;
    repeat (2) @(posedge clk) acked <= 0;
    @(posedge clk);
    `CHK(rbe, 1'b1)
    repeat (3) @(posedge clk);
    bus(1, OFS_IRQ_ST, 32'h1f);
    phy <= 0;
    repeat (4) @(posedge clk);
    `CHK({f_idle, f_fwd}, 2'b10)
    bus(0, OFS_IRQ_ST, 0);
    `CHK(q, 32'h02)
    bus(1, OFS_CTRL, 32'h0);
    phy <= 1;
    repeat (3) @(posedge clk);
    `CHK({f_idle, f_init}, 2'b10)
    bus(0, OFS_CTRL, 0);
    `CHK(q, 32'h0)
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(0, OFS_STATUS, 0);
    `CHK(q, 32'h12)
    final_report();
  end
endmodule // tb_top
`default_nettype wire
